/* common/pmx_consts.svh */
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
`define PMX_BIT0      0
`define PMX_BIT1      1
`define PMX_BIT2      2
`define PMX_BIT3      3
`define PMX_BIT4      4
`define PMX_BIT5      5
`define PMX_BIT6      6
`define PMX_BIT7      7
`define PMX_OFF       1'h0
`define PMX_ON        1'h1
`define PMX_PORT_RST  8'h00
`define PMX_GPORT_RST 6'h00
`define PMX_JTAG_PU   8'hb0
`endif

/* common/pmx_pkg.sv */
package pmx_pkg;
	typedef logic [7:0] pmx_byte_t;
	typedef enum logic [2:0]
	{
		PMX_SHIFT_NONE = 3'h1,
		PMX_SHIFT_IR   = 3'h2,
		PMX_SHIFT_DR   = 3'h4
	} pmx_shift_t;
endpackage : pmx_pkg

/* verilog/pmx_sync2.sv */
`timescale 1ns/10ps
`include "pmx_consts.svh"
module pmx_sync2
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_ff;
	logic sync_ff;
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			meta_ff <= `PMX_OFF;
			sync_ff <= `PMX_OFF;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end
	assign sync_out = sync_ff;
endmodule : pmx_sync2

/* verilog/pmx_pin_ovr.sv */
`timescale 1ns/10ps
`include "pmx_consts.svh"
module pmx_pin_ovr
(
	input  wire logic pullup_global_disable,
	input  wire logic reg_dir,
	input  wire logic reg_out,
	input  wire logic pullup_override_en,
	input  wire logic pullup_override_val,
	input  wire logic dir_override_en,
	input  wire logic dir_override_val,
	input  wire logic value_override_en,
	input  wire logic value_override_val,
	input  wire logic din_override_en,
	input  wire logic din_override_val,
	input  wire logic sleep_din_off,
	output logic      pin_pullup,
	output logic      pin_oe,
	output logic      pin_out,
	output logic      pin_din_en
);
	wire reg_pullup;
	wire def_din;
	// register path: pull-up only on an input with a one written
	assign reg_pullup = reg_out & ~reg_dir & ~pullup_global_disable;
	assign def_din    = ~sleep_din_off;
	assign pin_pullup = pullup_override_en ? pullup_override_val : reg_pullup; // [R20]
	assign pin_oe     = dir_override_en ? dir_override_val : reg_dir; // [R20]
	assign pin_out    = value_override_en ? value_override_val : reg_out; // [R20]
	assign pin_din_en = din_override_en ? din_override_val : def_din; // [R20]
endmodule : pmx_pin_ovr

/* verilog/pmx_port_efg.sv */
`timescale 1ns/10ps
`include "pmx_consts.svh"
// Overview of operation
// [R1] receiver enable forces pin e0 input
// [R2] e0 pull-up follows out bit unless disabled
// [R3] e0 input on with mask and group
// [R4] e0 carries programming data in (small package)
// [R5] ext irqs force input; e5/e4 compare outputs
// [R6] e1 transmit output, e2 clock output
// [R7] software keeps port f outputs still converting
// [R8] jtag pull-ups on f7 f5 f4 survive reset
// [R9] jtag frees f7..f4: input, din off
// [R10] f6 drives only in shift states
// [R11] f7 feeds test data in
// [R12] f5 steers tap state machine
// [R13] tap runs on test clock
// [R14] async timer makes g4 oscillator input
// [R15] async timer makes g3 oscillator output; code does so only with rtc_ext_clk_sel low
// [R16] software sets g5 direction for compare
// [R17] g2 carries address latch strobe
// [R18] g1 carries read strobe
// [R19] ext memory forces g2..g0 output strobes
// [R20] override enable selects override value
module pmx_port_efg
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             pullup_global_disable,
	input  wire logic             sleep_din_off,
	input  wire logic             small_package,
	input  wire pmx_pkg::pmx_byte_t porte_dir,
	input  wire pmx_pkg::pmx_byte_t porte_out,
	input  wire pmx_pkg::pmx_byte_t portf_dir,
	input  wire pmx_pkg::pmx_byte_t portf_out,
	input  wire logic [5:0]       portg_dir,
	input  wire logic [5:0]       portg_out,
	input  wire logic             uart0_rx_en,
	input  wire logic             uart0_tx_en,
	input  wire logic             uart0_tx_line,
	input  wire logic             uart0_clk_oe,
	input  wire logic             uart0_ext_clk,
	input  wire logic             pin_change_mask8,
	input  wire logic             pin_change_group1_en,
	input  wire logic [3:0]       ext_irq_en,
	input  wire logic             timer3_cmp_c_en,
	input  wire logic             timer3_cmp_c_out,
	input  wire logic             timer3_cmp_b_en,
	input  wire logic             timer3_cmp_b_out,
	input  wire logic             jtag_port_enable,
	input  wire pmx_pkg::pmx_shift_t tap_shift_state,
	input  wire logic             tap_data_out,
	input  wire logic             timer2_async_sel,
	input  wire logic             rtc_ext_clk_sel,
	input  wire logic             timer0_cmp_b_en,
	input  wire logic             timer0_cmp_b_out,
	input  wire logic             xmem_enable,
	input  wire logic             addr_latch_strobe,
	input  wire logic             xmem_rd_strobe,
	input  wire logic             xmem_wr_strobe,
	input  wire pmx_pkg::pmx_byte_t porte_pin_in,
	input  wire pmx_pkg::pmx_byte_t portf_pin_in,
	input  wire logic [5:0]       portg_pin_in,
	output pmx_pkg::pmx_byte_t    porte_pullup,
	output pmx_pkg::pmx_byte_t    porte_oe,
	output pmx_pkg::pmx_byte_t    porte_o,
	output pmx_pkg::pmx_byte_t    porte_din,
	output pmx_pkg::pmx_byte_t    portf_pullup,
	output pmx_pkg::pmx_byte_t    portf_oe,
	output pmx_pkg::pmx_byte_t    portf_o,
	output pmx_pkg::pmx_byte_t    portf_din,
	output logic [5:0]            portg_pullup,
	output logic [5:0]            portg_oe,
	output logic [5:0]            portg_o,
	output logic [5:0]            portg_din,
	output logic                  uart0_rx_line,
	output logic                  serial_prog_data_in,
	output logic                  pin_change_src8,
	output logic [3:0]            ext_irq_in,
	output logic                  tap_data_in,
	output logic                  tap_mode_sel,
	output logic                  tap_clk,
	output logic                  rtc_osc_in_sel,
	output logic                  rtc_osc_out_sel
);
	// per-pin override bundles: pullup/dir/value/din enables and values
	logic [7:0] e_pullup_override_en, e_puov, e_dir_override_en, e_ddov, e_value_override_en, e_pvov, e_din_override_en, e_dieov;
	logic [7:0] f_pullup_override_en, f_puov, f_dir_override_en, f_ddov, f_value_override_en, f_pvov, f_din_override_en, f_dieov;
	logic [5:0] g_pullup_override_en, g_puov, g_dir_override_en, g_ddov, g_value_override_en, g_pvov, g_din_override_en, g_dieov;
	logic [7:0] e_din_raw;
	logic [7:0] f_din_raw;
	logic [5:0] g_din_raw;
	logic [7:0] e_sync;
	logic [7:0] f_sync;
	logic [5:0] g_sync;
	wire        shift_out_state;
	wire        e0_pu_val;
	wire        osc_pair;

	// any state other than a shift leaves the data-out pin floating
	assign shift_out_state = (tap_shift_state == pmx_pkg::PMX_SHIFT_IR)
		| (tap_shift_state == pmx_pkg::PMX_SHIFT_DR); // [R10]
	assign e0_pu_val = porte_out[`PMX_BIT0] & ~pullup_global_disable; // [R2]
	// a crystal needs both pins; an external clock on g4 leaves g3 to the port
	assign osc_pair  = timer2_async_sel & ~rtc_ext_clk_sel;

	// port e
	always_comb
	begin
		e_pullup_override_en  = `PMX_PORT_RST;
		e_puov  = `PMX_PORT_RST;
		e_dir_override_en  = `PMX_PORT_RST;
		e_ddov  = `PMX_PORT_RST;
		e_value_override_en  = `PMX_PORT_RST;
		e_pvov  = `PMX_PORT_RST;
		e_din_override_en = `PMX_PORT_RST;
		e_dieov = `PMX_PORT_RST;
		e_pullup_override_en[`PMX_BIT0] = uart0_rx_en; // [R1]
		e_puov[`PMX_BIT0] = e0_pu_val; // [R2]
		e_dir_override_en[`PMX_BIT0] = uart0_rx_en; // [R1]
		e_din_override_en[`PMX_BIT0] = pin_change_mask8 & pin_change_group1_en; // [R3]
		e_dieov[`PMX_BIT0] = `PMX_ON; // [R3]
		e_pullup_override_en[`PMX_BIT1] = uart0_tx_en; // [R6]
		e_dir_override_en[`PMX_BIT1] = uart0_tx_en; // [R6]
		e_ddov[`PMX_BIT1] = `PMX_ON; // [R6]
		e_value_override_en[`PMX_BIT1] = uart0_tx_en; // [R6]
		e_pvov[`PMX_BIT1] = uart0_tx_line; // [R6]
		e_dir_override_en[`PMX_BIT2] = uart0_clk_oe; // [R6]
		e_ddov[`PMX_BIT2] = `PMX_ON; // [R6]
		e_value_override_en[`PMX_BIT2] = uart0_clk_oe; // [R6]
		e_pvov[`PMX_BIT2] = uart0_ext_clk; // [R6]
		e_value_override_en[`PMX_BIT4] = timer3_cmp_b_en; // [R5]
		e_pvov[`PMX_BIT4] = timer3_cmp_b_out; // [R5]
		e_value_override_en[`PMX_BIT5] = timer3_cmp_c_en; // [R5]
		e_pvov[`PMX_BIT5] = timer3_cmp_c_out; // [R5]
		// enabled interrupt inputs stay readable even with din off in sleep
		e_din_override_en[`PMX_BIT7:`PMX_BIT4] = ext_irq_en; // [R5]
		e_dieov[`PMX_BIT7:`PMX_BIT4] = {4{`PMX_ON}}; // [R5]
	end

	// port f: upper nibble goes to the test port
	always_comb
	begin
		f_pullup_override_en  = `PMX_PORT_RST;
		f_puov  = `PMX_PORT_RST;
		f_dir_override_en  = `PMX_PORT_RST;
		f_ddov  = `PMX_PORT_RST;
		f_value_override_en  = `PMX_PORT_RST;
		f_pvov  = `PMX_PORT_RST;
		f_din_override_en = `PMX_PORT_RST;
		f_dieov = `PMX_PORT_RST;
		f_pullup_override_en[`PMX_BIT7:`PMX_BIT4]  = {4{jtag_port_enable}}; // [R8]
		// pull-ups are pure logic of the enable, so rst cannot drop them
		f_puov  = `PMX_JTAG_PU; // [R8]
		f_dir_override_en[`PMX_BIT7:`PMX_BIT4]  = {4{jtag_port_enable}}; // [R9]
		f_ddov[`PMX_BIT6] = shift_out_state; // [R10]
		f_value_override_en[`PMX_BIT6] = jtag_port_enable; // [R10]
		f_pvov[`PMX_BIT6] = tap_data_out; // [R10]
		f_din_override_en[`PMX_BIT7:`PMX_BIT4] = {4{jtag_port_enable}}; // [R9]
	end

	// port g
	always_comb
	begin
		g_pullup_override_en  = `PMX_GPORT_RST;
		g_puov  = `PMX_GPORT_RST;
		g_dir_override_en  = `PMX_GPORT_RST;
		g_ddov  = `PMX_GPORT_RST;
		g_value_override_en  = `PMX_GPORT_RST;
		g_pvov  = `PMX_GPORT_RST;
		g_din_override_en = `PMX_GPORT_RST;
		g_dieov = `PMX_GPORT_RST;
		// g5 takes the compare value only; its direction stays with software
		g_value_override_en[`PMX_BIT5] = timer0_cmp_b_en;
		g_pvov[`PMX_BIT5] = timer0_cmp_b_out;
		g_pullup_override_en[`PMX_BIT4] = timer2_async_sel; // [R14]
		g_dir_override_en[`PMX_BIT4] = timer2_async_sel; // [R14]
		g_din_override_en[`PMX_BIT4] = timer2_async_sel; // [R14]
		g_dieov[`PMX_BIT4] = rtc_ext_clk_sel; // [R14]
		// g3 only drives the crystal, so its din is cut to save power
		g_pullup_override_en[`PMX_BIT3] = osc_pair; // [R15]
		g_dir_override_en[`PMX_BIT3] = osc_pair; // [R15]
		g_din_override_en[`PMX_BIT3] = osc_pair; // [R15]
		g_pullup_override_en[`PMX_BIT2:`PMX_BIT0] = {3{xmem_enable}}; // [R19]
		g_dir_override_en[`PMX_BIT2:`PMX_BIT0] = {3{xmem_enable}}; // [R19]
		g_ddov[`PMX_BIT2:`PMX_BIT0] = {3{`PMX_ON}}; // [R19]
		g_value_override_en[`PMX_BIT2:`PMX_BIT0] = {3{xmem_enable}}; // [R19]
		g_pvov[`PMX_BIT2] = addr_latch_strobe; // [R17]
		g_pvov[`PMX_BIT1] = xmem_rd_strobe; // [R18]
		g_pvov[`PMX_BIT0] = xmem_wr_strobe;
	end

	// every pin passes two flops; core logic reads test pins f7, f5 and f4 straight from the pin
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_e
			pmx_pin_ovr u_e
			(
				.pullup_global_disable (pullup_global_disable),
				.reg_dir               (porte_dir[i]),
				.reg_out               (porte_out[i]),
				.pullup_override_en    (e_pullup_override_en[i]),
				.pullup_override_val   (e_puov[i]),
				.dir_override_en       (e_dir_override_en[i]),
				.dir_override_val      (e_ddov[i]),
				.value_override_en     (e_value_override_en[i]),
				.value_override_val    (e_pvov[i]),
				.din_override_en       (e_din_override_en[i]),
				.din_override_val      (e_dieov[i]),
				.sleep_din_off         (sleep_din_off),
				.pin_pullup            (porte_pullup[i]),
				.pin_oe                (porte_oe[i]),
				.pin_out               (porte_o[i]),
				.pin_din_en            (e_din_raw[i])
			);
			pmx_sync2 u_es
			(
				.sys_clk  (sys_clk),
				.rst      (rst),
				.async_in (porte_pin_in[i]),
				.sync_out (e_sync[i])
			);
			pmx_pin_ovr u_f
			(
				.pullup_global_disable (pullup_global_disable),
				.reg_dir               (portf_dir[i]),
				.reg_out               (portf_out[i]),
				.pullup_override_en    (f_pullup_override_en[i]),
				.pullup_override_val   (f_puov[i]),
				.dir_override_en       (f_dir_override_en[i]),
				.dir_override_val      (f_ddov[i]),
				.value_override_en     (f_value_override_en[i]),
				.value_override_val    (f_pvov[i]),
				.din_override_en       (f_din_override_en[i]),
				.din_override_val      (f_dieov[i]),
				.sleep_din_off         (sleep_din_off),
				.pin_pullup            (portf_pullup[i]),
				.pin_oe                (portf_oe[i]),
				.pin_out               (portf_o[i]),
				.pin_din_en            (f_din_raw[i])
			);
			pmx_sync2 u_fs
			(
				.sys_clk  (sys_clk),
				.rst      (rst),
				.async_in (portf_pin_in[i]),
				.sync_out (f_sync[i])
			);
		end
		for (i = 0; i < 6; i++)
		begin : g_g
			pmx_pin_ovr u_g
			(
				.pullup_global_disable (pullup_global_disable),
				.reg_dir               (portg_dir[i]),
				.reg_out               (portg_out[i]),
				.pullup_override_en    (g_pullup_override_en[i]),
				.pullup_override_val   (g_puov[i]),
				.dir_override_en       (g_dir_override_en[i]),
				.dir_override_val      (g_ddov[i]),
				.value_override_en     (g_value_override_en[i]),
				.value_override_val    (g_pvov[i]),
				.din_override_en       (g_din_override_en[i]),
				.din_override_val      (g_dieov[i]),
				.sleep_din_off         (sleep_din_off),
				.pin_pullup            (portg_pullup[i]),
				.pin_oe                (portg_oe[i]),
				.pin_out               (portg_o[i]),
				.pin_din_en            (g_din_raw[i])
			);
			pmx_sync2 u_gs
			(
				.sys_clk  (sys_clk),
				.rst      (rst),
				.async_in (portg_pin_in[i]),
				.sync_out (g_sync[i])
			);
		end
	endgenerate

	// din enables leave unregistered so the port block can gate its readback
	assign porte_din = e_din_raw;
	assign portf_din = f_din_raw;
	assign portg_din = g_din_raw;

	// synchronised pin values gated by the digital input enable
	assign uart0_rx_line       = e_sync[`PMX_BIT0] & e_din_raw[`PMX_BIT0];
	// programming data skips the din gate: it is used while the core is held
	assign serial_prog_data_in = small_package & e_sync[`PMX_BIT0]; // [R4]
	assign pin_change_src8     = e_sync[`PMX_BIT0] & e_din_raw[`PMX_BIT0]; // [R3]
	assign ext_irq_in          = e_sync[`PMX_BIT7:`PMX_BIT4] & e_din_raw[`PMX_BIT7:`PMX_BIT4];
	// test pins bypass the din gate; the tap itself runs on its own clock pin
	assign tap_data_in  = jtag_port_enable & portf_pin_in[`PMX_BIT7]; // [R11]
	assign tap_mode_sel = jtag_port_enable & portf_pin_in[`PMX_BIT5]; // [R12]
	assign tap_clk      = jtag_port_enable & portf_pin_in[`PMX_BIT4]; // [R13]
	// oscillator pins are handed over whole; the analog path needs no sync
	assign rtc_osc_in_sel  = timer2_async_sel; // [R14]
	assign rtc_osc_out_sel = osc_pair; // [R15]
	// f_sync and g_sync feed nothing here but unused_sync; g5 needs portg_dir set
	wire unused_sync;
	assign unused_sync = ^{f_sync, g_sync};
endmodule : pmx_port_efg

/* testbench/pmx_port_efg_assertions.sv */
`timescale 1ns/10ps
module pmx_port_efg_assertions
(
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                pullup_global_disable,
	input wire pmx_pkg::pmx_byte_t  porte_out,
	input wire logic                uart0_rx_en,
	input wire logic                uart0_tx_en,
	input wire logic                uart0_tx_line,
	input wire logic                pin_change_mask8,
	input wire logic                pin_change_group1_en,
	input wire logic [3:0]          ext_irq_en,
	input wire logic                jtag_port_enable,
	input wire pmx_pkg::pmx_shift_t tap_shift_state,
	input wire logic                tap_data_out,
	input wire logic                timer2_async_sel,
	input wire logic                rtc_ext_clk_sel,
	input wire logic                xmem_enable,
	input wire logic                addr_latch_strobe,
	input wire logic                xmem_rd_strobe,
	input wire logic                xmem_wr_strobe,
	input wire pmx_pkg::pmx_byte_t  porte_pin_in,
	input wire pmx_pkg::pmx_byte_t  porte_pullup,
	input wire pmx_pkg::pmx_byte_t  porte_oe,
	input wire pmx_pkg::pmx_byte_t  porte_o,
	input wire pmx_pkg::pmx_byte_t  porte_din,
	input wire pmx_pkg::pmx_byte_t  portf_pullup,
	input wire pmx_pkg::pmx_byte_t  portf_oe,
	input wire pmx_pkg::pmx_byte_t  portf_o,
	input wire pmx_pkg::pmx_byte_t  portf_din,
	input wire logic [5:0]          portg_pullup,
	input wire logic [5:0]          portg_oe,
	input wire logic [5:0]          portg_o,
	input wire logic [5:0]          portg_din,
	input wire logic                uart0_rx_line,
	input wire logic                rtc_osc_in_sel,
	input wire logic                rtc_osc_out_sel
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// the pin must sit still through both sync stages before its sample can be judged
	sequence e0_held;
		(!rst && porte_din[0] && $stable(porte_din[0]) && $stable(porte_pin_in[0])) [*3];
	endsequence
	property p_e0_rx_in;
		uart0_rx_en |-> !porte_oe[0]
			&& porte_pullup[0] == (porte_out[0] && !pullup_global_disable);
	endproperty
	property p_e_irq_din;
		ext_irq_en != 4'h0 |-> (ext_irq_en & ~porte_din[7:4]) == 4'h0;
	endproperty
	property p_jtag_free;
		jtag_port_enable |-> portf_din[7:4] == 4'h0
			&& {portf_oe[7], portf_oe[5:4]} == 3'h0;
	endproperty
	property p_tdo;
		jtag_port_enable |-> portf_oe[6] == (tap_shift_state != pmx_pkg::PMX_SHIFT_NONE)
			&& (!portf_oe[6] || portf_o[6] == tap_data_out);
	endproperty
	property p_osc_in;
		timer2_async_sel |-> rtc_osc_in_sel && !portg_oe[4] && !portg_pullup[4];
	endproperty
	property p_osc_out;
		timer2_async_sel && !rtc_ext_clk_sel |-> rtc_osc_out_sel && !portg_oe[3]
			&& !portg_pullup[3] && !portg_din[3];
	endproperty
	property p_xmem;
		xmem_enable |-> portg_oe[2:0] == 3'h7 && portg_pullup[2:0] == 3'h0
			&& portg_o[2:0] == {addr_latch_strobe, xmem_rd_strobe, xmem_wr_strobe};
	endproperty
	AST_E0_RX_IN: assert property (p_e0_rx_in)
		else $error("e0 not held as pulled input");
	AST_E0_SYNC: assert property (e0_held |-> uart0_rx_line == porte_pin_in[0])
		else $error("receive line does not follow e0");
	AST_E0_PCINT: assert property (pin_change_mask8 && pin_change_group1_en |-> porte_din[0])
		else $error("e0 input not forced on");
	AST_E_IRQ_DIN: assert property (p_e_irq_din)
		else $error("irq pin input not forced on");
	AST_E1_TX: assert property (uart0_tx_en |-> porte_oe[1] && porte_o[1] == uart0_tx_line)
		else $error("e1 not driving transmit line");
	AST_JTAG_PU: assert property (disable iff (1'b0) jtag_port_enable |-> portf_pullup[7:4] == 4'hb)
		else $error("test pin pull-ups wrong");
	AST_JTAG_FREE: assert property (p_jtag_free)
		else $error("test pins left in general use");
	AST_TDO: assert property (p_tdo)
		else $error("test data out drive wrong");
	AST_OSC_IN: assert property (p_osc_in)
		else $error("g4 not handed to oscillator");
	AST_OSC_OUT: assert property (p_osc_out)
		else $error("g3 not handed to oscillator");
	AST_XMEM: assert property (p_xmem)
		else $error("memory strobes not on g2..g0");
endmodule : pmx_port_efg_assertions

bind pmx_port_efg pmx_port_efg_assertions chk_u (.*);

/* testbench/pmx_pin_model.sv */
`timescale 1ns/10ps
module pmx_pin_model
#(
	parameter int W = 8
)
(
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] o,
	input  wire logic [W-1:0] pu_en,
	input  wire logic [W-1:0] ext_en,
	input  wire logic [W-1:0] ext_val,
	input  wire logic         sys_clk,
	output logic      [W-1:0] pin
);
	// an undriven pin without pull-up wanders each cycle, so a stale level never passes
	logic [W-1:0] float_ff = '0;
	always @(posedge sys_clk)
		float_ff <= ~float_ff;
	assign pin = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu_en | float_ff));
endmodule : pmx_pin_model

/* testbench/pmx_port_efg_bench.sv */
`timescale 1ns/10ps
module pmx_port_efg_bench;
	logic sys_clk, rst, pullup_global_disable, sleep_din_off, small_package;
	pmx_pkg::pmx_byte_t porte_dir, porte_out, portf_dir, portf_out, e_ext_en, e_ext_val;
	pmx_pkg::pmx_byte_t f_ext_en, f_ext_val, porte_pin_in, portf_pin_in;
	pmx_pkg::pmx_byte_t porte_pullup, porte_oe, porte_o, porte_din;
	pmx_pkg::pmx_byte_t portf_pullup, portf_oe, portf_o, portf_din;
	logic [5:0] portg_dir, portg_out, portg_pin_in, portg_pullup, portg_oe, portg_o, portg_din;
	logic uart0_rx_en, uart0_tx_en, uart0_tx_line, uart0_clk_oe, uart0_ext_clk;
	logic pin_change_mask8, pin_change_group1_en, timer3_cmp_c_en, timer3_cmp_c_out;
	logic timer3_cmp_b_en, timer3_cmp_b_out, jtag_port_enable, tap_data_out;
	logic timer2_async_sel, rtc_ext_clk_sel, timer0_cmp_b_en, timer0_cmp_b_out, xmem_enable;
	logic addr_latch_strobe, xmem_rd_strobe, xmem_wr_strobe, uart0_rx_line, serial_prog_data_in;
	logic pin_change_src8, tap_data_in, tap_mode_sel, tap_clk, rtc_osc_in_sel, rtc_osc_out_sel;
	logic [3:0] ext_irq_en, ext_irq_in;
	pmx_pkg::pmx_shift_t tap_shift_state;
	int n_mismatch, n_checks, cyc;

	pmx_port_efg dut_u (.*);
	pmx_pin_model #(.W(8)) e_pins_u (.oe(porte_oe), .o(porte_o), .pu_en(porte_pullup),
		.ext_en(e_ext_en), .ext_val(e_ext_val), .sys_clk(sys_clk), .pin(porte_pin_in));
	pmx_pin_model #(.W(8)) f_pins_u (.oe(portf_oe), .o(portf_o), .pu_en(portf_pullup),
		.ext_en(f_ext_en), .ext_val(f_ext_val), .sys_clk(sys_clk), .pin(portf_pin_in));
	pmx_pin_model #(.W(6)) g_pins_u (.oe(portg_oe), .o(portg_o), .pu_en(portg_pullup),
		.ext_en(6'h00), .ext_val(6'h00), .sys_clk(sys_clk), .pin(portg_pin_in));

	always #5 sys_clk = ~sys_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			begin
				n_mismatch++;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic t_plain;
		@(posedge sys_clk);
		porte_dir <= 8'h5a;
		porte_out <= 8'h3c;
		portf_out <= 8'hf0;
		#1;
		chk({porte_oe, porte_o}, 16'h5a3c);
		chk({porte_pullup, porte_din}, 16'h24ff);
		chk(portf_pullup, 8'hf0);
		$display("t_plain done");
	endtask : t_plain

	task automatic t_e0;
		@(posedge sys_clk);
		uart0_rx_en <= 1'b1;
		porte_dir <= 8'h01;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			porte_out <= {7'h0, i[0]};
			pullup_global_disable <= i[1];
			#1;
			chk({porte_oe[0], porte_pullup[0]}, {1'b0, i[0] & ~i[1]});
		end
		@(posedge sys_clk);
		pullup_global_disable <= 1'b0;
		{e_ext_en, e_ext_val, small_package} <= {8'h01, 8'h01, 1'b1};
		repeat (3) @(posedge sys_clk);
		#1;
		chk({uart0_rx_line, serial_prog_data_in}, 2'h3);
		@(posedge sys_clk);
		{small_package, sleep_din_off, pin_change_mask8, pin_change_group1_en} <= 4'h7;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({serial_prog_data_in, porte_din[0], pin_change_src8}, 3'h3);
		@(posedge sys_clk);
		pin_change_mask8 <= 1'b0;
		{e_ext_en, e_ext_val} <= {8'hf1, 8'ha1};
		repeat (3) @(posedge sys_clk);
		#1;
		chk({porte_din[0], pin_change_src8}, 2'h0);
		$display("t_e0 done");
	endtask : t_e0

	task automatic t_e_hi;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			ext_irq_en <= 4'h1 << i;
			#1;
			chk({porte_din[7:4], ext_irq_in}, {4'h1 << i, 4'ha & (4'h1 << i)});
		end
		for (int i = 0; i < 2; i++)
		begin
			@(posedge sys_clk);
			{porte_dir, timer3_cmp_c_en, timer3_cmp_b_en, uart0_tx_en, uart0_clk_oe} <= {8'h30, 4'hf};
			{timer3_cmp_c_out, timer3_cmp_b_out} <= {i[0], ~i[0]};
			{uart0_tx_line, uart0_ext_clk} <= {i[0], ~i[0]};
			#1;
			chk({porte_o[5:4], porte_oe[2:1], porte_o[2:1]}, {i[0], ~i[0], 2'h3, ~i[0], i[0]});
		end
		$display("t_e_hi done");
	endtask : t_e_hi

	task automatic t_g;
		@(posedge sys_clk);
		{portg_dir, portg_out, timer2_async_sel} <= {6'h1f, 6'h10, 1'b1};
		sleep_din_off <= 1'b0;
		#1;
		chk({portg_oe[4:3], portg_pullup[4], rtc_osc_in_sel, rtc_osc_out_sel}, 5'h03);
		chk(portg_din[4:3], 2'h0);
		@(posedge sys_clk);
		rtc_ext_clk_sel <= 1'b1;
		#1;
		chk({portg_oe[4:3], portg_pullup[4], rtc_osc_in_sel, rtc_osc_out_sel}, 5'h0a);
		chk(portg_din[4:3], 2'h3);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			{xmem_enable, portg_dir, portg_out} <= {1'b1, 6'h00, 6'h07};
			{addr_latch_strobe, xmem_rd_strobe, xmem_wr_strobe} <= i[2:0];
			#1;
			chk({portg_oe[2:0], portg_pullup[2:0], portg_o[2:0]}, {6'h38, i[2:0]});
		end
		for (int i = 0; i < 2; i++)
		begin
			@(posedge sys_clk);
			portg_dir <= 6'h20;
			{timer0_cmp_b_en, timer0_cmp_b_out} <= {1'b1, i[0]};
			#1;
			chk({portg_oe[5], portg_o[5]}, {1'b1, i[0]});
		end
		$display("t_g done");
	endtask : t_g

	task automatic t_jtag;
		@(posedge sys_clk);
		{jtag_port_enable, rst, portf_dir, f_ext_en, f_ext_val} <= {2'h3, 8'hff, 8'hb0, 8'h80};
		#1;
		chk(portf_pullup & 8'hf0, 8'hb0);
		chk({tap_data_in, tap_mode_sel, tap_clk}, 3'h4);
		@(posedge sys_clk);
		{rst, f_ext_val} <= {1'b0, 8'h30};
		#1;
		chk({portf_din[7:4], portf_oe[7:4]}, 8'h00);
		chk({tap_data_in, tap_mode_sel, tap_clk}, 3'h3);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge sys_clk);
			tap_shift_state <= i ? pmx_pkg::PMX_SHIFT_DR : pmx_pkg::PMX_SHIFT_IR;
			tap_data_out <= i[0];
			#1;
			chk({portf_oe[6], portf_o[6], portf_pullup[6]}, {1'b1, i[0], 1'b0});
		end
		$display("t_jtag done");
	endtask : t_jtag

	initial
	begin
		{sys_clk, pullup_global_disable, sleep_din_off, small_package} = '0;
		{porte_dir, porte_out, portf_dir, portf_out, e_ext_en, e_ext_val, f_ext_en, f_ext_val} = '0;
		{portg_dir, portg_out, ext_irq_en, uart0_rx_en, uart0_tx_en, uart0_tx_line} = '0;
		{uart0_clk_oe, uart0_ext_clk, pin_change_mask8, pin_change_group1_en} = '0;
		{timer3_cmp_c_en, timer3_cmp_c_out, timer3_cmp_b_en, timer3_cmp_b_out} = '0;
		{jtag_port_enable, tap_data_out, timer2_async_sel, rtc_ext_clk_sel} = '0;
		{timer0_cmp_b_en, timer0_cmp_b_out, xmem_enable} = '0;
		{addr_latch_strobe, xmem_rd_strobe, xmem_wr_strobe} = '0;
		tap_shift_state = pmx_pkg::PMX_SHIFT_NONE;
		{n_mismatch, n_checks, cyc} = '0;
		rst = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_plain();
		t_e0();
		t_e_hi();
		t_g();
		t_jtag();
		conclude();
	end
endmodule : pmx_port_efg_bench
